// ---- hdl/ple_defines.svh ----
// Register offsets, field positions, reset values and timing constants for the level encoder
`ifndef PLE_DEFINES_SVH
`define PLE_DEFINES_SVH

`define PLE_ADDR_W 8
`define PLE_OFS_LOW_CFG 8'h4F
`define PLE_OFS_HIGH_CFG 8'h50
`define PLE_OFS_CTRL 8'h60
`define PLE_OFS_STATUS 8'h61
`define PLE_TB_HI 15
`define PLE_TB_LO 14
`define PLE_HC_HI 13
`define PLE_HC_LO 7
`define PLE_LC_HI 6
`define PLE_LC_LO 0
`define PLE_RST_LOW_CFG 16'h007F
`define PLE_RST_HIGH_CFG 16'h3F80
`define PLE_HIGH_CFG_WMASK 16'h3FFF
`define PLE_TB_SEL_16 2'h0
`define PLE_TB_SEL_64 2'h1
`define PLE_TB_SEL_256 2'h2
`define PLE_TB_SEL_1024 2'h3
`define PLE_TB_16 10'h00F
`define PLE_TB_64 10'h03F
`define PLE_TB_256 10'h0FF
`define PLE_TB_1024 10'h3FF

`endif

// ---- hdl/ple_pkg.sv ----
// Types shared by the level encoder files
package ple_pkg;
    typedef struct packed {
        logic [6:0] high_count;
        logic [6:0] low_count;
    } ple_pair_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ple_bus_req_t;

    typedef enum logic [1:0] {
        PLE_STATIC_LOW,
        PLE_STATIC_HIGH,
        PLE_PULSE
    } ple_shape_t;
endpackage : ple_pkg

// ---- hdl/ple_tick_gen.sv ----
// Time-base tick generator for the level encoder
`timescale 1ns/1ps
`default_nettype none
`include "ple_defines.svh"
module ple_tick_gen
    import ple_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic restart,
    input wire logic [1:0] tb_sel,
    output logic tick
);
    logic [9:0] cnt_q;
    logic [9:0] last_cnt;

    // Terminal count for the selected time base
    always_comb begin
        case (tb_sel)
            `PLE_TB_SEL_16: last_cnt = `PLE_TB_16;
            `PLE_TB_SEL_64: last_cnt = `PLE_TB_64;
            `PLE_TB_SEL_256: last_cnt = `PLE_TB_256;
            default: last_cnt = `PLE_TB_1024;
        endcase
    end

    // Free counter, held at zero by restart while the pin is not pulsing
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cnt_q <= 10'h000;
        end else if (clk_en) begin
            if (restart || cnt_q >= last_cnt) begin
                cnt_q <= 10'h000;
            end else begin
                cnt_q <= cnt_q + 10'h001;
            end
        end
    end

    assign tick = clk_en && !restart && (cnt_q >= last_cnt);
endmodule : ple_tick_gen
`default_nettype wire

// ---- hdl/pwm_level_encoder.sv ----
// Pulse-width level encoder for the general pin zero monitor output
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "ple_defines.svh"
module pwm_level_encoder
    import ple_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic level_in,
    output logic monitor_output_function,
    output logic monitor_output_oe
);
    typedef enum logic [1:0] {
        PLE_ST_IDLE,
        PLE_ST_HIGH,
        PLE_ST_LOW
    } ple_state_t;

    ple_bus_req_t req;
    logic [15:0] low_cfg_q;
    logic [15:0] high_cfg_q;
    logic enable_q;
    logic level_meta_q;
    logic level_sync_q;
    logic cur_level_q;
    ple_state_t state_q;
    logic [6:0] phase_cnt_q;
    logic pin_q;
    logic [15:0] reg_rdata_q;
    ple_pair_t low_pair;
    ple_pair_t high_pair;
    ple_pair_t sel_pair;
    ple_shape_t shape;
    logic [1:0] tb_sel;
    logic tick;
    logic restart;
    logic period_end;

    assign req.addr = reg_addr;
    assign req.wdata = reg_wdata;
    assign req.wr = reg_wr;
    assign req.rd = reg_rd;

    // Field extraction for both counter pairs
    assign low_pair.high_count = low_cfg_q[`PLE_HC_HI:`PLE_HC_LO];
    assign low_pair.low_count = low_cfg_q[`PLE_LC_HI:`PLE_LC_LO];
    assign high_pair.high_count = high_cfg_q[`PLE_HC_HI:`PLE_HC_LO];
    assign high_pair.low_count = high_cfg_q[`PLE_LC_HI:`PLE_LC_LO];
    assign tb_sel = low_cfg_q[`PLE_TB_HI:`PLE_TB_LO];
    assign sel_pair = cur_level_q ? high_pair : low_pair;

    // Classify the chosen pair as static or pulsed
    always_comb begin
        if (sel_pair.high_count == 7'h00) begin
            shape = PLE_STATIC_LOW;
        end else if (sel_pair.low_count == 7'h00) begin
            shape = PLE_STATIC_HIGH;
        end else begin
            shape = PLE_PULSE;
        end
    end

    // Register writes; reserved top bits of the high-level register stay zero
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            low_cfg_q <= `PLE_RST_LOW_CFG;
            high_cfg_q <= `PLE_RST_HIGH_CFG;
            enable_q <= 1'b0;
        end else if (clk_en && req.wr) begin
            case (req.addr)
                `PLE_OFS_LOW_CFG: low_cfg_q <= req.wdata;
                `PLE_OFS_HIGH_CFG: high_cfg_q <= req.wdata & `PLE_HIGH_CFG_WMASK;
                `PLE_OFS_CTRL: enable_q <= req.wdata[0];
                default: ;
            endcase
        end
    end

    // Read data one cycle after the strobe, zero for unmapped offsets
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            reg_rdata_q <= 16'h0000;
        end else if (clk_en) begin
            if (req.rd) begin
                case (req.addr)
                    `PLE_OFS_LOW_CFG: reg_rdata_q <= low_cfg_q;
                    `PLE_OFS_HIGH_CFG: reg_rdata_q <= high_cfg_q;
                    `PLE_OFS_CTRL: reg_rdata_q <= {15'h0000, enable_q};
                    `PLE_OFS_STATUS: reg_rdata_q <= {12'h000, cur_level_q, pin_q,
                                                     state_q == PLE_ST_HIGH, enable_q};
                    default: reg_rdata_q <= 16'h0000;
                endcase
            end else begin
                reg_rdata_q <= 16'h0000;
            end
        end
    end

    // Level input comes from outside the clock domain: two-stage synchroniser
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            level_meta_q <= 1'b0;
            level_sync_q <= 1'b0;
        end else if (clk_en) begin
            level_meta_q <= level_in;
            level_sync_q <= level_meta_q;
        end
    end

    // Time base held at zero while not pulsing; it runs on across period ends so no clock is lost
    assign restart = clk_en && (!enable_q || shape != PLE_PULSE);
    assign period_end = tick && state_q == PLE_ST_LOW && phase_cnt_q == 7'h01;

    ple_tick_gen u_tick (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .restart(restart),
        .tb_sel(tb_sel),
        .tick(tick)
    );

    // A new level is taken only at a period boundary, while static or while disabled
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cur_level_q <= 1'b0;
        end else if (clk_en) begin
            if (!enable_q || shape != PLE_PULSE || period_end) begin
                cur_level_q <= level_sync_q;
            end
        end
    end

    // Phase sequencer: high phase then low phase, each counted in ticks
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_q <= PLE_ST_IDLE;
            phase_cnt_q <= 7'h00;
        end else if (clk_en) begin
            if (!enable_q || shape != PLE_PULSE) begin
                state_q <= PLE_ST_IDLE;
                phase_cnt_q <= 7'h00;
            end else begin
                case (state_q)
                    PLE_ST_IDLE: begin
                        state_q <= PLE_ST_HIGH;
                        phase_cnt_q <= sel_pair.high_count;
                    end
                    PLE_ST_HIGH: begin
                        if (tick) begin
                            if (phase_cnt_q == 7'h01) begin
                                state_q <= PLE_ST_LOW;
                                phase_cnt_q <= sel_pair.low_count;
                            end else begin
                                phase_cnt_q <= phase_cnt_q - 7'h01;
                            end
                        end
                    end
                    PLE_ST_LOW: begin
                        if (tick) begin
                            if (phase_cnt_q == 7'h01) begin
                                state_q <= PLE_ST_IDLE;
                                phase_cnt_q <= 7'h00;
                            end else begin
                                phase_cnt_q <= phase_cnt_q - 7'h01;
                            end
                        end
                    end
                    default: begin
                        state_q <= PLE_ST_IDLE;
                        phase_cnt_q <= 7'h00;
                    end
                endcase
            end
        end
    end

    // Pin value: static levels direct, pulses follow the phase
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pin_q <= 1'b0;
        end else if (clk_en) begin
            if (!enable_q) begin
                pin_q <= 1'b0;
            end else begin
                case (shape)
                    PLE_STATIC_HIGH: pin_q <= 1'b1;
                    PLE_STATIC_LOW: pin_q <= 1'b0;
                    default: pin_q <= (state_q == PLE_ST_IDLE) ||
                                      (state_q == PLE_ST_HIGH &&
                                       !(tick && phase_cnt_q == 7'h01)) ||
                                      (state_q == PLE_ST_LOW && period_end);
                endcase
            end
        end
    end

    // Output enable follows the software enable
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            monitor_output_oe <= 1'b0;
        end else if (clk_en) begin
            monitor_output_oe <= enable_q;
        end
    end

    assign monitor_output_function = pin_q;
    assign reg_rdata = reg_rdata_q;
endmodule : pwm_level_encoder
`default_nettype wire

// ---- sim/ple_rx_model.sv ----
// Receiver model that times each steady stretch of the encoded pin
`timescale 1ns/1ps
`default_nettype none
module ple_rx_model (
    input wire logic ref_clk,
    input wire logic pin,
    output logic [15:0] hi_w,
    output logic [15:0] lo_w,
    output logic [15:0] edges
);
    logic [15:0] run_q = 16'h0001;
    logic last_q = 1'b0;
    initial begin
        hi_w = 16'h0000;
        lo_w = 16'h0000;
        edges = 16'h0000;
    end
    // Width in clocks of the stretch that just ended
    always @(posedge ref_clk) begin
        if (pin !== last_q) begin
            if (last_q)
                hi_w <= run_q;
            else
                lo_w <= run_q;
            edges <= edges + 16'h0001;
            run_q <= 16'h0001;
        end else begin
            run_q <= run_q + 16'h0001;
        end
        last_q <= pin;
    end
endmodule : ple_rx_model
`default_nettype wire

// ---- sim/ple_chk.sv ----
// Port checker for the level encoder
`timescale 1ns/1ps
`default_nettype none
module ple_chk (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic level_in,
    input wire logic monitor_output_function,
    input wire logic monitor_output_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // Read port relations
    idle_rdata_a: assert property (clk_en && !reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not idle");
    rsvd_bits_a: assert property (clk_en && reg_rd && reg_addr == 8'h50 |=> reg_rdata[15:14] == 2'h0)
        else $error("reserved bits not zero");
    unmapped_read_a: assert property (clk_en && reg_rd && !(reg_addr inside {8'h4F, 8'h50, 8'h60, 8'h61})
        |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    status_en_a: assert property (clk_en && reg_rd && reg_addr == 8'h61 |=> reg_rdata[0] == $past(monitor_output_oe))
        else $error("status enable bit wrong");
    // Pin relations
    oe_gate_a: assert property (!monitor_output_oe |-> !monitor_output_function)
        else $error("pin high while released");
    oe_write_a: assert property (clk_en && reg_wr && reg_addr == 8'h60 |-> ##2 monitor_output_oe == $past(reg_wdata[0], 2))
        else $error("enable write not applied");
    high_min_a: assert property ($rose(monitor_output_function) |-> (monitor_output_function || !monitor_output_oe)[*8])
        else $error("high phase too short");
    low_min_a: assert property ($fell(monitor_output_function) && monitor_output_oe
        |-> (!monitor_output_function || !monitor_output_oe)[*8])
        else $error("low phase too short");
endmodule : ple_chk
bind pwm_level_encoder ple_chk i_ple_chk (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .level_in(level_in), .monitor_output_function(monitor_output_function),
    .monitor_output_oe(monitor_output_oe));
`default_nettype wire

// ---- sim/testbench.sv ----
// Register and pin tests for the level encoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic level_in = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata, hi_w, lo_w, edges, v, tb;
    logic monitor_output_function, monitor_output_oe;
    int failures = 0;
    int checked = 0;
    // Clock at 50 ns
    initial forever #25 ref_clk = ~ref_clk;
    pwm_level_encoder i_pwm_level_encoder (.ref_clk(ref_clk), .rstn(rstn), .clk_en(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .level_in(level_in),
        .monitor_output_function(monitor_output_function), .monitor_output_oe(monitor_output_oe));
    ple_rx_model i_ple_rx_model (.ref_clk(ref_clk), .pin(monitor_output_function),
        .hi_w(hi_w), .lo_w(lo_w), .edges(edges));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge ref_clk);
    endtask : rd
    // Release the pin, load one register and level, then drive again
    task automatic cfg(input logic [7:0] a, input logic [15:0] d, input logic lv);
        wr(8'h60, 16'h0000);
        wr(a, d);
        level_in <= lv;
        repeat (4) @(posedge ref_clk);
        wr(8'h60, 16'h0001);
    endtask : cfg
    // Pin must sit still at one level
    task automatic flat(input logic lv);
        logic [15:0] e0;
        repeat (20) @(posedge ref_clk);
        e0 = edges;
        repeat (300) @(posedge ref_clk);
        chk(edges - e0, 16'h0000, "edge count");
        chk({15'h0000, monitor_output_function}, {15'h0000, lv}, "static pin");
    endtask : flat
    // Wait for settled periods, then compare phase widths
    task automatic pulse(input logic [15:0] eh, input logic [15:0] el);
        int n;
        logic [15:0] e0;
        n = 0;
        e0 = edges;
        while (edges - e0 < 16'h0005 && n < 20000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 20000)
            failures++;
        chk(hi_w, eh, "high width");
        chk(lo_w, el, "low width");
    endtask : pulse
    task automatic finish_test;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    initial begin
        #(60000 * 50);
        failures++;
        finish_test;
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        rd(8'h4F, v);
        chk(v, 16'h007F, "low cfg reset");
        rd(8'h60, v);
        chk(v, 16'h0000, "ctrl reset");
        rd(8'h70, v);
        chk(v, 16'h0000, "unmapped read");
        cfg(8'h71, 16'hFFFF, 1'b1);
        flat(1'b1);
        rd(8'h50, v);
        chk(v, 16'h3F80, "high cfg reset");
        rd(8'h61, v);
        chk(v & 16'h0001, 16'h0001, "status enable");
        wr(8'h50, 16'hFFFF);
        rd(8'h50, v);
        chk(v, 16'h3FFF, "high cfg reserved");
        for (int t = 0; t < 4; t++) begin
            tb = 16'h0010 << (2 * t);
            cfg(8'h4F, {t[1:0], 7'h02, 7'h03}, 1'b0);
            pulse(tb << 1, tb * 16'h0003);
        end
        cfg(8'h4F, 16'h0005, 1'b0);
        flat(1'b0);
        cfg(8'h4F, 16'h0000, 1'b0);
        flat(1'b0);
        cfg(8'h50, 16'h0082, 1'b1);
        pulse(16'h0010, 16'h0020);
        cfg(8'h50, 16'h0000, 1'b1);
        flat(1'b0);
        cfg(8'h50, 16'h0180, 1'b1);
        flat(1'b1);
        finish_test;
    end
endmodule : testbench
`default_nettype wire
